// *** glf_asserts.sv ***
`timescale 1ns/1ps
// ****************************************************************
// Checks on the negotiation outputs.
// ****************************************************************
module glf_asserts (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_multi_node_strap,
  input wire logic i_page_valid,
  input wire glf_pkg::glf_page_t i_page,
  input wire logic i_partner_drop,
  input wire logic [1:0] o_tx_gig_ability,
  input wire logic o_ms_multi_advert,
  input wire glf_pkg::glf_res_t o_result,
  input wire logic o_renegotiate,
  input wire logic o_force_link
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  sequence page_taken;
    i_page_valid && o_ms_multi_advert && !o_force_link;
  endsequence
  sequence gig_page;
    page_taken ##0 (i_page.g_fd && o_tx_gig_ability[0]);
  endsequence
  res_valid_a:
    assert property (page_taken |=> o_result.valid)
    else $error("No result after a taken page.");
  gig_best_a:
    assert property (gig_page |=> o_result.speed == 2'h2 && o_result.full)
    else $error("Common gigabit full duplex not chosen.");
  multi_master_a:
    assert property (gig_page ##0 (!i_page.manual && !i_page.multi)
      |=> o_result.master && !o_result.ms_fault)
    else $error("Multi-node lost to a single-node partner.");
  manual_role_a:
    assert property (gig_page ##0 i_page.manual
      |=> o_result.master == !$past(i_page.manual_master))
    else $error("Wrong role against a manual partner.");
  ms_gig_only_a:
    assert property (o_result.valid && o_result.speed != 2'h2
      |-> !o_result.master && !o_result.ms_fault)
    else $error("Role resolved below gigabit.");
  pause_full_a:
    assert property (o_result.valid && !o_result.full
      |-> !o_result.pause && !o_result.asym)
    else $error("Pause reported in half duplex.");
  strap_single_a:
    assert property ((!i_multi_node_strap) [*6] |-> !o_ms_multi_advert)
    else $error("Multi-node advertised with strap low.");
  drop_unforce_a:
    assert property (i_partner_drop && o_force_link |-> ##[1:2] !o_force_link)
    else $error("Forced link kept after partner drop.");
  fall_nogig_a:
    assert property ($rose(o_renegotiate) && $past(o_tx_gig_ability) != 2'h0
      |-> ##[0:2] o_tx_gig_ability == 2'h0)
    else $error("Gigabit still advertised after fallback.");
  reneg_pulse_a:
    assert property (o_renegotiate |=> !o_renegotiate)
    else $error("Renegotiate longer than one cycle.");
endmodule : glf_asserts

bind glf_top glf_asserts chk_u (.i_clk, .i_reset_n, .i_multi_node_strap,
  .i_page_valid, .i_page, .i_partner_drop, .o_tx_gig_ability,
  .o_ms_multi_advert, .o_result, .o_renegotiate, .o_force_link);

// *** glf_defines.svh ***
`ifndef GLF_DEFINES_SVH
`define GLF_DEFINES_SVH

// ****************************************************************
// Register indexes; the byte address is four times the index.
// ****************************************************************
`define GLF_IDX_LOCAL_ADV 10'h004
`define GLF_IDX_PARTNER 10'h005
`define GLF_IDX_CRITERIA 10'h013
`define GLF_IDX_EXP_CFG 10'h1C0
`define GLF_IDX_STATUS 10'h1F0
`define GLF_IDX_GIG_CTRL 10'h1F1

// ****************************************************************
// Field positions.
// ****************************************************************
`define GLF_ADV_10HD 5
`define GLF_ADV_10FD 6
`define GLF_ADV_100HD 7
`define GLF_ADV_100FD 8
`define GLF_ADV_PAUSE 10
`define GLF_ADV_ASYM 11
`define GLF_CRIT_AN 2
`define GLF_CRIT_CRC 1
`define GLF_CRIT_IE 0
`define GLF_EXP_SF_EN 3
`define GLF_GIG_FD 0
`define GLF_GIG_HD 1

// ****************************************************************
// Reset values and counts.
// ****************************************************************
`define GLF_LOCAL_ADV_RST 16'h01E1
`define GLF_CRITERIA_RST 16'h0000
`define GLF_EXP_CFG_RST 16'h0000
`define GLF_GIG_CTRL_RST 16'h0003
`define GLF_RETRY_DEFAULT 3'h5

`endif

// *** glf_partner.sv ***
`timescale 1ns/1ps
// ****************************************************************
// Link partner across the cable.
// ****************************************************************
module glf_partner (
  input wire logic i_clk,
  output logic o_page_valid,
  output glf_pkg::glf_page_t o_page,
  output logic [3:0] o_event
);
  initial begin
    o_page_valid = 1'h0;
    o_page = '0;
    o_event = 4'h0;
  end
  // The page is garbage outside its valid cycle, so no stale match.
  task automatic send_page(input glf_pkg::glf_page_t p);
    @(posedge i_clk);
    o_page_valid <= 1'h1;
    o_page <= p;
    @(posedge i_clk);
    o_page_valid <= 1'h0;
    o_page <= ~p;
  endtask : send_page
  // Event bits: 0 failed attempt, 1 drop, 2 CRC error, 3 idle error.
  task automatic pulse(input logic [3:0] ev, input int n, input int gap);
    repeat (n) begin
      @(posedge i_clk);
      o_event <= ev;
      @(posedge i_clk);
      o_event <= 4'h0;
      repeat (gap) @(posedge i_clk);
    end
  endtask : pulse
endmodule : glf_partner

// *** glf_pkg.sv ***
package glf_pkg;

  typedef enum logic [1:0] {
    GLF_SPD_10 = 2'h0,
    GLF_SPD_100 = 2'h1,
    GLF_SPD_1000 = 2'h2
  } glf_speed_t;

  // Gray codes along negotiate, linked, fallback.
  typedef enum logic [1:0] {
    GLF_ST_NEG = 2'h0,
    GLF_ST_LINKED = 2'h1,
    GLF_ST_FALLBACK = 2'h3,
    GLF_ST_FORCED = 2'h2
  } glf_state_t;

  // Partner page as handed over by the pulse engine.
  typedef struct packed {
    logic [15:0] word;
    logic g_fd;
    logic g_hd;
    logic manual;
    logic manual_master;
    logic multi;
    logic [10:0] seed;
  } glf_page_t;

  typedef struct packed {
    logic valid;
    glf_speed_t speed;
    logic full;
    logic master;
    logic ms_fault;
    logic pause;
    logic asym;
  } glf_res_t;

endpackage : glf_pkg

// *** glf_top.sv ***
// Our own choice: register access over AHB-Lite.
`timescale 1ns/1ps
`include "glf_defines.svh"
// Contract
// - Speed fallback runs only while the expanded enable bit is one.
// - Criteria bits: 2 negotiation failure, 1 CRC rate, 0 idle rate.
// - A fired criterion renegotiates at the next lower advertised speed.
// - Five failed gigabit attempts drop to a lower speed.
// - Five error-rate link drops drop to a lower speed.
// - Partner drop or unplugged cable reloads the retry count to five.
// - Fallback only leaves gigabit; never 100 down to 10.
// - Enable bit zero, the reset value, selects retry forced link mode.
// - Forced link mode uses criteria bits 1:0 only.
// - Five error drops force the link at highest common speed.
// - Retrying has no overall timeout.
// - Master/slave is resolved only when gigabit was selected.
// - Strap 0 advertises single node, strap 1 multi-node; the code advertises single node whenever the negotiation enable strap is low.
// - Multi beats single; manual partner master or slave wins.
// - Same node option settles roles by comparing seeds.
// - Pause exchange is reported only for full duplex.
// - Advertisement bits 10 and 11 send pause and asymmetric pause.
// - Partner pause bits land in partner record bits 10 and 11.
// - Priority: 1000F, 1000H, 100F, 100H, 10F, 10H.
module glf_top #(
  parameter int ERR_WINDOW = 100000,
  parameter int CRC_LIMIT = 16,
  parameter int IDLE_LIMIT = 16
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  input wire logic i_negotiation_enable_strap,
  input wire logic i_multi_node_strap,
  input wire logic i_page_valid,
  input wire glf_pkg::glf_page_t i_page,
  input wire logic i_an_fail,
  input wire logic i_partner_drop,
  input wire logic i_crc_err,
  input wire logic i_idle_err,
  output logic [15:0] o_tx_ability,
  output logic [1:0] o_tx_gig_ability,
  output logic o_ms_multi_advert,
  output glf_pkg::glf_res_t o_result,
  output logic o_renegotiate,
  output logic o_force_link
);

  // ****************************************************************
  // Reset release and strap synchronisers.
  // ****************************************************************
  logic [1:0] rst_sync_q;
  logic rst_n;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];
  logic [2:0] en_sync_q;
  logic [2:0] multi_sync_q;
  logic negotiation_enable_strap_q;
  logic multi_q;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      en_sync_q <= 3'h0;
      multi_sync_q <= 3'h0;
    end else begin
      en_sync_q <= {en_sync_q[1:0], i_negotiation_enable_strap};
      multi_sync_q <= {multi_sync_q[1:0], i_multi_node_strap};
    end
  end

  // A strap change counts only once the second and third stages agree.
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      negotiation_enable_strap_q <= 1'b0;
      multi_q <= 1'b0;
    end else begin
      if (en_sync_q[2] == en_sync_q[1]) begin
        negotiation_enable_strap_q <= en_sync_q[2];
      end
      if (multi_sync_q[2] == multi_sync_q[1]) begin
        multi_q <= multi_sync_q[2];
      end
    end
  end

  // ****************************************************************
  // Bus slave.
  // ****************************************************************
  logic [15:0] local_adv_q;
  logic [15:0] partner_q;
  logic [15:0] criteria_q;
  logic [15:0] exp_cfg_q;
  logic [15:0] gig_ctrl_q;
  logic [15:0] status;
  logic wr_pend_q;
  logic [9:0] wr_idx_q;
  logic addr_ok;
  logic take;
  logic [9:0] idx;
  logic [15:0] rd_val;

  assign take = i_hsel && i_htrans[1] && i_hready;
  assign idx = i_haddr[11:2];
  assign addr_ok = (i_haddr[31:12] == 20'h00000);
  always_comb begin
    rd_val = 16'h0000;
    if (addr_ok) begin
      unique case (idx)
        `GLF_IDX_LOCAL_ADV: rd_val = local_adv_q;
        `GLF_IDX_PARTNER: rd_val = partner_q;
        `GLF_IDX_CRITERIA: rd_val = criteria_q;
        `GLF_IDX_EXP_CFG: rd_val = exp_cfg_q;
        `GLF_IDX_STATUS: rd_val = status;
        `GLF_IDX_GIG_CTRL: rd_val = gig_ctrl_q;
        default: rd_val = 16'h0000;
      endcase
    end
  end

  // Zero wait: reads sample in the address phase, so a fresh write is unseen.
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_q <= 1'b0;
      wr_idx_q <= 10'h000;
      o_hrdata <= 32'h00000000;
      o_hreadyout <= 1'b0;
      o_hresp <= 1'b0;
    end else begin
      o_hreadyout <= 1'b1;
      wr_pend_q <= take && i_hwrite && addr_ok;
      wr_idx_q <= idx;
      if (take && !i_hwrite) begin
        o_hrdata <= {16'h0000, rd_val};
      end
    end
  end

  logic wr_exp;
  assign wr_exp = wr_pend_q && (wr_idx_q == `GLF_IDX_EXP_CFG);

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      local_adv_q <= `GLF_LOCAL_ADV_RST;
      criteria_q <= `GLF_CRITERIA_RST;
      exp_cfg_q <= `GLF_EXP_CFG_RST;
      gig_ctrl_q <= `GLF_GIG_CTRL_RST;
    end else begin
      if (wr_pend_q && (wr_idx_q == `GLF_IDX_LOCAL_ADV)) begin
        local_adv_q <= i_hwdata[15:0];
      end
      if (wr_pend_q && (wr_idx_q == `GLF_IDX_CRITERIA)) begin
        criteria_q <= i_hwdata[15:0];
      end
      if (wr_exp) begin
        exp_cfg_q <= i_hwdata[15:0];
      end
      if (wr_pend_q && (wr_idx_q == `GLF_IDX_GIG_CTRL)) begin
        gig_ctrl_q <= i_hwdata[15:0];
      end
    end
  end

  // ****************************************************************
  // Error-rate link drop detection.
  // ****************************************************************
  logic [31:0] win_q;
  logic [15:0] crc_cnt_q;
  logic [15:0] idle_cnt_q;
  logic err_drop_q;
  logic win_end;
  logic crc_hit;
  logic idle_hit;
  assign win_end = (win_q == 32'h00000000);
  assign crc_hit = criteria_q[`GLF_CRIT_CRC] && i_crc_err &&
                   (crc_cnt_q == 16'(CRC_LIMIT - 1));
  assign idle_hit = criteria_q[`GLF_CRIT_IE] && i_idle_err &&
                    (idle_cnt_q == 16'(IDLE_LIMIT - 1));

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      win_q <= 32'h00000000;
      crc_cnt_q <= 16'h0000;
      idle_cnt_q <= 16'h0000;
      err_drop_q <= 1'b0;
    end else begin
      err_drop_q <= crc_hit || idle_hit;
      if (win_end || crc_hit || idle_hit) begin
        win_q <= 32'(ERR_WINDOW - 1);
        crc_cnt_q <= 16'h0000;
        idle_cnt_q <= 16'h0000;
      end else begin
        win_q <= win_q - 32'h00000001;
        if (i_crc_err) begin
          crc_cnt_q <= crc_cnt_q + 16'h0001;
        end
        if (i_idle_err) begin
          idle_cnt_q <= idle_cnt_q + 16'h0001;
        end
      end
    end
  end

  // ****************************************************************
  // Retry counting and mode state.
  // ****************************************************************
  glf_pkg::glf_state_t state_q;
  logic [2:0] retry_q;
  logic sf_mode;
  logic gig_up;
  logic an_ev;
  logic err_ev;
  logic retry_ev;
  logic exhaust;
  logic lower_adv;
  assign sf_mode = exp_cfg_q[`GLF_EXP_SF_EN];
  assign gig_up = o_result.valid &&
                  (o_result.speed == glf_pkg::GLF_SPD_1000);
  assign an_ev = sf_mode && criteria_q[`GLF_CRIT_AN] && i_an_fail &&
                 (gig_ctrl_q[1:0] != 2'h0);
  // Only bits 1:0 count in forced link mode
  assign err_ev = err_drop_q && gig_up;
  // Counting stops once gigabit has been left
  assign retry_ev = (an_ev || err_ev) &&
                    ((state_q == glf_pkg::GLF_ST_NEG) ||
                     (state_q == glf_pkg::GLF_ST_LINKED));
  assign exhaust = retry_ev && (retry_q == 3'h1);
  assign lower_adv = |local_adv_q[`GLF_ADV_100FD:`GLF_ADV_10HD];

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      retry_q <= `GLF_RETRY_DEFAULT;
    end else if (i_partner_drop || exhaust) begin
      retry_q <= `GLF_RETRY_DEFAULT;
    end else if (retry_ev) begin
      retry_q <= retry_q - 3'h1;
    end
  end

  // No overall timeout: a flapping partner keeps this retrying for ever.
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= glf_pkg::GLF_ST_NEG;
      o_renegotiate <= 1'b0;
      o_force_link <= 1'b0;
    end else begin
      o_renegotiate <= 1'b0;
      unique case (state_q)
        glf_pkg::GLF_ST_NEG, glf_pkg::GLF_ST_LINKED: begin
          if (exhaust && sf_mode && lower_adv) begin
            state_q <= glf_pkg::GLF_ST_FALLBACK;
            o_renegotiate <= 1'b1;
          end else if (exhaust && !sf_mode) begin
            state_q <= glf_pkg::GLF_ST_FORCED;
            o_force_link <= 1'b1;
          end else if (i_partner_drop) begin
            state_q <= glf_pkg::GLF_ST_NEG;
          end else if (i_page_valid && negotiation_enable_strap_q) begin
            state_q <= glf_pkg::GLF_ST_LINKED;
          end
        end
        glf_pkg::GLF_ST_FALLBACK: begin
          if (wr_exp && !i_hwdata[`GLF_EXP_SF_EN]) begin
            state_q <= glf_pkg::GLF_ST_NEG;
            o_renegotiate <= 1'b1;
          end
        end
        glf_pkg::GLF_ST_FORCED: begin
          if (i_partner_drop) begin
            state_q <= glf_pkg::GLF_ST_NEG;
            o_force_link <= 1'b0;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Priority, master/slave and pause resolution.
  // ****************************************************************
  logic gfd_eff;
  logic ghd_eff;
  logic [15:0] common;
  glf_pkg::glf_res_t res;
  logic seed_master;
  // Gigabit is withheld only while fallen back
  assign gfd_eff = gig_ctrl_q[`GLF_GIG_FD] &&
                   (state_q != glf_pkg::GLF_ST_FALLBACK);
  assign ghd_eff = gig_ctrl_q[`GLF_GIG_HD] &&
                   (state_q != glf_pkg::GLF_ST_FALLBACK);
  assign common = local_adv_q & i_page.word;
  assign seed_master = (gig_ctrl_q[12:2] > i_page.seed);

  always_comb begin
    res = '0;
    res.valid = 1'b1;
    if (gfd_eff && i_page.g_fd) begin
      res.speed = glf_pkg::GLF_SPD_1000;
      res.full = 1'b1;
    end else if (ghd_eff && i_page.g_hd) begin
      res.speed = glf_pkg::GLF_SPD_1000;
    end else if (common[`GLF_ADV_100FD]) begin
      res.speed = glf_pkg::GLF_SPD_100;
      res.full = 1'b1;
    end else if (common[`GLF_ADV_100HD]) begin
      res.speed = glf_pkg::GLF_SPD_100;
    end else if (common[`GLF_ADV_10FD]) begin
      res.speed = glf_pkg::GLF_SPD_10;
      res.full = 1'b1;
    end else if (common[`GLF_ADV_10HD]) begin
      res.speed = glf_pkg::GLF_SPD_10;
    end else begin
      res.valid = 1'b0;
    end
    if (res.valid && (res.speed == glf_pkg::GLF_SPD_1000)) begin
      // Manual partner or node option decides
      if (i_page.manual) begin
        res.master = !i_page.manual_master;
      end else if (multi_q != i_page.multi) begin
        res.master = multi_q;
      end else if (gig_ctrl_q[12:2] == i_page.seed) begin
        res.ms_fault = 1'b1;
      end else begin
        res.master = seed_master;
      end
    end
    if (res.full) begin
      res.pause = i_page.word[`GLF_ADV_PAUSE];
      res.asym = i_page.word[`GLF_ADV_ASYM];
    end
  end

  // The forced link keeps the highest common speed already held.
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_result <= '0;
      partner_q <= 16'h0000;
    end else if (i_partner_drop && (state_q != glf_pkg::GLF_ST_FORCED)) begin
      o_result <= '0;
    end else if (i_page_valid && negotiation_enable_strap_q &&
                 (state_q != glf_pkg::GLF_ST_FORCED)) begin
      o_result <= res;
      partner_q <= i_page.word;
    end
  end

  // ****************************************************************
  // Transmitted ability words and status.
  // ****************************************************************
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_tx_ability <= 16'h0000;
      o_tx_gig_ability <= 2'h0;
      o_ms_multi_advert <= 1'b0;
    end else begin
      o_tx_ability <= local_adv_q;
      o_tx_gig_ability <= {ghd_eff, gfd_eff};
      o_ms_multi_advert <= negotiation_enable_strap_q && multi_q;
    end
  end

  // Pause fields are a report only; the MAC resolves pause itself.
  assign status = {3'h0, retry_q, state_q, o_result.asym,
                   o_result.pause, o_result.ms_fault, o_result.master,
                   o_result.full, o_result.speed, o_result.valid};

endmodule : glf_top

// *** testbench.sv ***
`timescale 1ns/1ps
`include "glf_defines.svh"
// ****************************************************************
// Register and link scenarios.
// ****************************************************************
module testbench;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic hsel = 1'h0;
  logic hwrite = 1'h0;
  logic multi_strap = 1'h1;
  logic an_strap = 1'h1;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic hready, page_valid, ms_adv, reneg, frc, hresp;
  logic [3:0] ev;
  logic [15:0] tx_ab;
  logic [1:0] tx_gig;
  glf_pkg::glf_page_t page, gp;
  glf_pkg::glf_res_t res;
  int n_mismatch = 0;
  int n_compared = 0;
  int n_reneg = 0;
  int base;
  logic [3:0] crit_t [5] = '{4'h2, 4'h1, 4'h3, 4'h0, 4'h4};
  logic [3:0] ev_t [5] = '{4'h8, 4'h8, 4'h4, 4'hC, 4'h1};
  logic exp_t [5] = '{1'h0, 1'h1, 1'h1, 1'h0, 1'h0};

  always #5 clk = ~clk;
  always @(posedge clk) if (reneg === 1'h1) n_reneg++;

  glf_top #(.ERR_WINDOW(50), .CRC_LIMIT(2), .IDLE_LIMIT(2)) dut_u (
    .i_clk(clk), .i_reset_n(rst_n), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
    .i_hwdata(hwdata), .i_hready(hready), .o_hreadyout(hready),
    .o_hresp(hresp), .o_hrdata(hrdata),
    .i_negotiation_enable_strap(an_strap),
    .i_multi_node_strap(multi_strap), .i_page_valid(page_valid),
    .i_page(page), .i_an_fail(ev[0]), .i_partner_drop(ev[1]),
    .i_crc_err(ev[2]), .i_idle_err(ev[3]), .o_tx_ability(tx_ab),
    .o_tx_gig_ability(tx_gig), .o_ms_multi_advert(ms_adv),
    .o_result(res), .o_renegotiate(reneg), .o_force_link(frc));
  glf_partner lp_u (.i_clk(clk), .o_page_valid(page_valid), .o_page(page),
    .o_event(ev));

  task automatic tally_and_finish;
    if (n_mismatch == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string s, input logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (e !== g) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask : chk

  task automatic xfer(input logic wr, logic [9:0] idx, logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {20'h00000, idx, 2'h0};
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'h1 && n < 99);
    htrans <= 2'h0;
    hsel <= 1'h0;
    hwdata <= wd;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'h1 && n < 99);
    rd = hrdata;
    if (n >= 99) begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask : xfer

  task automatic rchk(input logic [9:0] idx, logic [31:0] e, string s);
    xfer(1'h0, idx, 32'h0);
    chk(s, e, rd);
  endtask : rchk

  function automatic glf_pkg::glf_page_t pg(input logic [15:0] w,
    logic [1:0] g, logic [2:0] m, logic [10:0] sd);
    return {w, g, m, sd};
  endfunction : pg

  task automatic page_chk(input glf_pkg::glf_page_t p, logic [1:0] sp,
    logic [4:0] f);
    lp_u.send_page(p);
    @(negedge clk);
    chk("result", {1'h1, sp, f}, res);
  endtask : page_chk

  // Each round is one error-rate link drop.
  task automatic rounds(input logic [3:0] e, input int n);
    repeat (n) begin
      lp_u.send_page(gp);
      lp_u.pulse(e, 3, 0);
      repeat (60) @(posedge clk);
    end
  endtask : rounds

  initial begin
    repeat (50000) @(posedge clk);
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    gp = pg(16'h0DE1, 2'h2, 3'h0, 11'h1);
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    repeat (10) @(posedge clk);
    chk("hreadyout", 1'h1, hready);
    chk("hresp", 1'h0, hresp);
    chk("multi advert", 1'h1, ms_adv);
    rchk(`GLF_IDX_LOCAL_ADV, 32'h01E1, "adv reset");
    rchk(`GLF_IDX_CRITERIA, 32'h0, "criteria reset");
    rchk(`GLF_IDX_EXP_CFG, 32'h0, "expanded reset");
    rchk(`GLF_IDX_GIG_CTRL, 32'h3, "gig ctrl reset");
    rchk(10'h3FF, 32'h0, "unmapped");
    xfer(1'h1, `GLF_IDX_LOCAL_ADV, 32'h0DE1);
    rchk(`GLF_IDX_LOCAL_ADV, 32'h0DE1, "adv");
    chk("tx ability", 16'h0DE1, tx_ab);
    page_chk(gp, 2'h2, 5'h1B);
    rchk(`GLF_IDX_PARTNER, 32'h0DE1, "partner record");
    xfer(1'h1, `GLF_IDX_PARTNER, 32'hFFFF);
    rchk(`GLF_IDX_PARTNER, 32'h0DE1, "partner ro");
    page_chk(pg(16'h0DE1, 2'h1, 3'h0, 11'h1), 2'h2, 5'h08);
    page_chk(pg(16'h0501, 2'h0, 3'h0, 11'h1), 2'h1, 5'h12);
    page_chk(pg(16'h0081, 2'h0, 3'h0, 11'h1), 2'h1, 5'h00);
    page_chk(pg(16'h0021, 2'h0, 3'h0, 11'h1), 2'h0, 5'h00);
    page_chk(pg(16'h0001, 2'h2, 3'h6, 11'h1), 2'h2, 5'h10);
    page_chk(pg(16'h0001, 2'h2, 3'h4, 11'h1), 2'h2, 5'h18);
    page_chk(pg(16'h0001, 2'h2, 3'h1, 11'h0), 2'h2, 5'h14);
    page_chk(pg(16'h0001, 2'h2, 3'h1, 11'h1), 2'h2, 5'h10);
    xfer(1'h1, `GLF_IDX_CRITERIA, 32'h2);
    rounds(4'h4, 2);
    xfer(1'h0, `GLF_IDX_STATUS, 32'h0);
    chk("retry count", 3'h3, rd[12:10]);
    lp_u.pulse(4'h2, 1, 2);
    xfer(1'h0, `GLF_IDX_STATUS, 32'h0);
    chk("retry reload", 3'h5, rd[12:10]);
    rounds(4'h4, 4);
    chk("early force", 1'h0, frc);
    rounds(4'h4, 1);
    chk("forced", 1'h1, frc);
    lp_u.pulse(4'h2, 1, 2);
    chk("unforced", 1'h0, frc);
    for (int i = 0; i < 5; i++) begin
      xfer(1'h1, `GLF_IDX_CRITERIA, {28'h0, crit_t[i]});
      rounds(ev_t[i], 5);
      chk("forced mode", exp_t[i], frc);
      lp_u.pulse(4'h2, 1, 2);
    end
    xfer(1'h1, `GLF_IDX_EXP_CFG, 32'h8);
    xfer(1'h1, `GLF_IDX_CRITERIA, 32'h4);
    lp_u.send_page(gp);
    base = n_reneg;
    lp_u.pulse(4'h1, 4, 2);
    chk("gig kept", 2'h3, tx_gig);
    lp_u.pulse(4'h1, 1, 4);
    chk("fallback", 2'h0, tx_gig);
    chk("renegotiate", base + 1, n_reneg);
    lp_u.send_page(pg(16'h0501, 2'h0, 3'h0, 11'h1));
    lp_u.pulse(4'h1, 5, 2);
    chk("no second drop", base + 1, n_reneg);
    xfer(1'h1, `GLF_IDX_EXP_CFG, 32'h0);
    repeat (4) @(posedge clk);
    chk("gig back", 2'h3, tx_gig);
    chk("exit renegotiate", base + 2, n_reneg);
    xfer(1'h1, `GLF_IDX_EXP_CFG, 32'h8);
    xfer(1'h1, `GLF_IDX_CRITERIA, 32'h2);
    rounds(4'h4, 5);
    chk("crc fallback", 2'h0, tx_gig);
    multi_strap <= 1'h0;
    repeat (10) @(posedge clk);
    chk("single node", 1'h0, ms_adv);
    multi_strap <= 1'h1;
    an_strap <= 1'h0;
    repeat (10) @(posedge clk);
    chk("strap off", 1'h0, ms_adv);
    page_chk(pg(16'h0021, 2'h0, 3'h0, 11'h1), 2'h2, 5'h1B);
    tally_and_finish();
  end
endmodule : testbench
